// ---- logic/gpt_unit.sv ----
`timescale 1ns/10ps
module gpt_unit #(
  parameter int TIMER_W = 16
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // Register port
  input  wire logic [gpt_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [gpt_pkg::BUS_W-1:0]  reg_wdata,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  output logic      [gpt_pkg::BUS_W-1:0]  reg_rdata,
  // Pins
  input  wire logic [2:0]                 aux_timer_input_pin,
  input  wire logic                       core_one_direction_pin,
  input  wire logic                       capture_trigger_pin,
  output logic                            core_one_toggle_pin,
  output logic                            core_two_toggle_pin,
  output logic                            cc_time_base_clock,
  // Interrupt
  output logic                            irq
);
  import gpt_pkg::*;

  if (TIMER_W < 8 || TIMER_W > BUS_W) begin
    $error("TIMER_W must lie between 8 and BUS_W");
  end

  localparam logic [PRE_W-1:0] BASE1_LAST = PRE_W'(BASE1_CYC - 1);
  localparam logic [PRE_W-1:0] BASE2_LAST = PRE_W'(BASE2_CYC - 1);

  // Edge match: sel[0] rising, sel[1] falling
  function automatic logic edge_hit(input logic [1:0] sel, input logic prv,
                                    input logic cur);
    edge_hit = (sel[0] & ~prv & cur) | (sel[1] & prv & ~cur);
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [N_PIN-1:0] meta_r;
  logic [N_PIN-1:0] sync_r;
  logic [N_PIN-1:0] prev_r;

  // Two stages, then one more for edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= {capture_trigger_pin, core_one_direction_pin, aux_timer_input_pin};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // ****************************************************************
  // Base ticks and prescalers
  // ****************************************************************
  logic [PRE_W-1:0] base1_r;
  logic [PRE_W-1:0] base2_r;
  logic [PRE_W-1:0] pre1_r;
  logic [PRE_W-1:0] pre2_r;
  logic             base1_tick;
  logic             base2_tick;

  assign base1_tick = (base1_r == BASE1_LAST);
  assign base2_tick = (base2_r == BASE2_LAST);

  // Base dividers limit the fastest step rate of each module
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base1_r <= '0;
      base2_r <= '0;
      pre1_r  <= '0;
      pre2_r  <= '0;
    end else begin
      base1_r <= base1_tick ? '0 : base1_r + PRE_W'(1);
      base2_r <= base2_tick ? '0 : base2_r + PRE_W'(1);
      pre1_r  <= base1_tick ? pre1_r + PRE_W'(1) : pre1_r;
      pre2_r  <= base2_tick ? pre2_r + PRE_W'(1) : pre2_r;
    end
  end

  // ****************************************************************
  // Registers and per-timer control decode
  // ****************************************************************
  logic [BUS_W-1:0]   ctl_r [N_TMR];
  logic [TIMER_W-1:0] cnt_r [N_TMR];
  logic [TIMER_W-1:0] capture_reload_register_r;
  logic [BUS_W-1:0]   capcfg_r;
  logic [N_IRQ-1:0]   stat_r;
  logic [N_IRQ-1:0]   mask_r;
  logic [2:0]         pend_r;
  logic               otl1_r;
  logic               otl1_prev_r;
  logic               otl2_r;
  logic               otl2_prev_r;
  mode_t              mode [N_TMR];
  logic [N_TMR-1:0]   step;
  logic [N_TMR-1:0]   down;
  logic [N_TMR-1:0]   ovf;
  logic [N_TMR-1:0]   wr_ctl;
  logic [N_TMR-1:0]   wr_cnt;
  logic [N_TMR-1:0]   cap_aux;
  logic [N_TMR-1:0]   rel_aux;
  logic               cap_evt;
  logic [N_IRQ-1:0]   ev;

  // Mode, step, direction and trigger decode for every timer
  always_comb begin
    logic [PS_W-1:0]  ps;
    logic [PRE_W-1:0] pmask;
    logic             tick;
    logic             lclk;
    logic [1:0]       esel;
    logic             pin_edge;
    ps       = '0;
    pmask    = '0;
    tick     = 1'b0;
    lclk     = 1'b0;
    esel     = '0;
    pin_edge = 1'b0;
    for (int i = 0; i < N_TMR; i++) begin
      mode[i]  = mode_t'(ctl_r[i][CTL_MODE_LSB +: MODE_W]);
      ps       = ctl_r[i][CTL_PS_LSB +: PS_W];
      pmask    = (PRE_W'(1) << ps) - PRE_W'(1);
      esel     = ctl_r[i][CTL_EDGE_LSB +: 2];
      wr_ctl[i] = reg_write && (reg_addr == ADR_CTL_BASE + ADDR_W'(i));
      wr_cnt[i] = reg_write && (reg_addr == ADR_CNT_BASE + ADDR_W'(i));
      if (i <= IDX_B) begin
        tick     = base1_tick && ((pre1_r & pmask) == '0);
        lclk     = edge_hit(esel, otl1_prev_r, otl1_r);
        pin_edge = edge_hit(esel, prev_r[i], sync_r[i]);
      end else begin
        tick     = base2_tick && ((pre2_r & pmask) == '0);
        lclk     = edge_hit(esel, otl2_prev_r, otl2_r);
        pin_edge = 1'b0;
      end
      step[i] = 1'b0;
      if (ctl_r[i][CTL_RUN]) begin
        case (mode[i])
          MODE_TIMER: step[i] = tick;
          MODE_COUNTER: step[i] = (i <= IDX_B) && base1_tick && pend_r[i % 3];
          MODE_GATE_LO: step[i] = (i <= IDX_B) && tick && !sync_r[i % 3];
          MODE_GATE_HI: step[i] = (i <= IDX_B) && tick && sync_r[i % 3];
          MODE_LATCH_CLK: step[i] = (i == IDX_A || i == IDX_B || i == IDX_C) && lclk;
          default: step[i] = 1'b0;
        endcase
      end
      down[i] = ctl_r[i][CTL_DOWN] ^ ((i == IDX_ONE) && ctl_r[i][CTL_EXTDIR]
                                      && sync_r[PIN_DIR]);
      ovf[i]  = step[i] && (down[i] ? (cnt_r[i] == '0) : (cnt_r[i] == '1));
      cap_aux[i] = (i == IDX_A || i == IDX_B) && (mode[i] == MODE_CAPTURE) && pin_edge;
      rel_aux[i] = (i == IDX_A || i == IDX_B) && (mode[i] == MODE_RELOAD)
                   && (ctl_r[i][CTL_TLTRIG] ? edge_hit(esel, otl1_prev_r, otl1_r)
                                            : pin_edge);
    end
  end

  assign cap_evt = edge_hit(capcfg_r[CAP_EDGE_LSB +: 2], prev_r[PIN_CAP],
                            sync_r[PIN_CAP]);
  assign ev = {cap_evt, ovf};

  // Pending external count events, consumed at the next base tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        pend_r[i] <= (pend_r[i] & ~base1_tick)
                     | edge_hit(ctl_r[i][CTL_EDGE_LSB +: 2], prev_r[i], sync_r[i]);
      end
    end
  end

  // ****************************************************************
  // Timer counters
  // ****************************************************************
  // Software write first, then capture/reload coupling, then counting
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N_TMR; i++) begin
        cnt_r[i] <= TIMER_W'(REG_RST);
      end
    end else begin
      for (int i = 0; i < N_TMR; i++) begin
        if (wr_cnt[i]) begin
          cnt_r[i] <= reg_wdata[TIMER_W-1:0];
        end else if (i == IDX_ONE && rel_aux[IDX_A]) begin
          cnt_r[i] <= cnt_r[IDX_A];
        end else if (i == IDX_ONE && rel_aux[IDX_B]) begin
          cnt_r[i] <= cnt_r[IDX_B];
        end else if (cap_aux[i]) begin
          cnt_r[i] <= cnt_r[IDX_ONE];
        end else if (i == IDX_C && cap_evt && capcfg_r[CAP_CLR]) begin
          cnt_r[i] <= '0;
        end else if (i == IDX_TWO && ovf[i] && ctl_r[i][CTL_RELTWO]) begin
          cnt_r[i] <= capture_reload_register_r;
        end else if (step[i]) begin
          cnt_r[i] <= down[i] ? cnt_r[i] - TIMER_W'(1) : cnt_r[i] + TIMER_W'(1);
        end
      end
    end
  end

  // Timer control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N_TMR; i++) begin
        ctl_r[i] <= CTL_RST;
      end
    end else begin
      for (int i = 0; i < N_TMR; i++) begin
        if (wr_ctl[i]) begin
          ctl_r[i] <= reg_wdata;
        end
      end
    end
  end

  // ****************************************************************
  // Toggle latches and outputs
  // ****************************************************************
  // Latches invert on every overflow or underflow of their core timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      otl1_r              <= 1'b0;
      otl1_prev_r         <= 1'b0;
      otl2_r              <= 1'b0;
      otl2_prev_r         <= 1'b0;
      core_one_toggle_pin <= 1'b0;
      core_two_toggle_pin <= 1'b0;
      cc_time_base_clock  <= 1'b0;
    end else begin
      otl1_r              <= otl1_r ^ ovf[IDX_ONE];
      otl1_prev_r         <= otl1_r;
      otl2_r              <= otl2_r ^ ovf[IDX_TWO];
      otl2_prev_r         <= otl2_r;
      core_one_toggle_pin <= (otl1_r ^ ovf[IDX_ONE]) & ctl_r[IDX_ONE][CTL_TOGOUT];
      core_two_toggle_pin <= (otl2_r ^ ovf[IDX_TWO]) & ctl_r[IDX_TWO][CTL_TOGOUT];
      cc_time_base_clock  <= ovf[IDX_TWO];
    end
  end

  // ****************************************************************
  // Capture register, configuration, interrupts
  // ****************************************************************
  // Capture register latches aux c; software may also write it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_reload_register_r <= TIMER_W'(REG_RST);
      capcfg_r <= REG_RST;
    end else begin
      if (reg_write && reg_addr == ADR_CAPTURE_RELOAD_REGISTER) begin
        capture_reload_register_r <= reg_wdata[TIMER_W-1:0];
      end else if (cap_evt) begin
        capture_reload_register_r <= cnt_r[IDX_C];
      end
      if (reg_write && reg_addr == ADR_CAPCFG) begin
        capcfg_r <= reg_wdata;
      end
    end
  end

  // Sticky status, write one to clear, new events win over the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_r <= '0;
      mask_r <= '0;
      irq    <= 1'b0;
    end else begin
      if (reg_write && reg_addr == ADR_STAT) begin
        stat_r <= (stat_r & ~reg_wdata[N_IRQ-1:0]) | ev;
      end else begin
        stat_r <= stat_r | ev;
      end
      if (reg_write && reg_addr == ADR_MASK) begin
        mask_r <= reg_wdata[N_IRQ-1:0];
      end
      irq <= |(stat_r & mask_r);
    end
  end

  // Read data, valid in the cycle after the read strobe only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (!reg_read) begin
      reg_rdata <= '0;
    end else if (reg_addr >= ADR_CTL_BASE && reg_addr < ADR_CTL_BASE + ADDR_W'(N_TMR)) begin
      reg_rdata <= ctl_r[3'(reg_addr - ADR_CTL_BASE)];
    end else if (reg_addr >= ADR_CNT_BASE && reg_addr < ADR_CNT_BASE + ADDR_W'(N_TMR)) begin
      reg_rdata <= BUS_W'(cnt_r[3'(reg_addr - ADR_CNT_BASE)]);
    end else if (reg_addr == ADR_CAPTURE_RELOAD_REGISTER) begin
      reg_rdata <= BUS_W'(capture_reload_register_r);
    end else if (reg_addr == ADR_CAPCFG) begin
      reg_rdata <= capcfg_r;
    end else if (reg_addr == ADR_STAT) begin
      reg_rdata <= BUS_W'(stat_r);
    end else if (reg_addr == ADR_MASK) begin
      reg_rdata <= BUS_W'(mask_r);
    end else begin
      reg_rdata <= '0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Module one base tick spacing
  AST_BASE1_SPACING: assert property (base1_tick |=> !base1_tick [*7])
    else $error("module one stepped faster than its resolution");

  // Module two base tick spacing
  AST_BASE2_SPACING: assert property (base2_tick |=> !base2_tick [*3])
    else $error("module two stepped faster than its resolution");

  // Latch one inverts after an overflow of core timer one
  AST_LATCH_ONE: assert property (ovf[IDX_ONE] |=> otl1_r != $past(otl1_r))
    else $error("latch one did not toggle");

  // Latch two inverts and time-base pulse follows
  AST_LATCH_TWO: assert property (ovf[IDX_TWO] |=> (otl2_r != $past(otl2_r))
                                  && cc_time_base_clock)
    else $error("latch two or time base pulse missing");

  // Capture copies core one into aux a
  AST_CAP_AUX: assert property (cap_aux[IDX_A] && !wr_cnt[IDX_A]
                                |=> cnt_r[IDX_A] == $past(cnt_r[IDX_ONE]))
    else $error("aux a capture value wrong");

  // Aux b holds while in reload mode with nothing touching it
  AST_AUX_HOLD: assert property (mode[IDX_B] == MODE_RELOAD && !wr_cnt[IDX_B]
                                 |=> $stable(cnt_r[IDX_B]))
    else $error("aux b counted while in reload mode");

  // Capture register takes aux c, optional clear follows
  AST_CAPTURE_RELOAD_REGISTER: assert property (cap_evt && !(reg_write && reg_addr == ADR_CAPTURE_RELOAD_REGISTER)
                               |=> capture_reload_register_r == $past(cnt_r[IDX_C]))
    else $error("capture register value wrong");

  AST_CLEAR_C: assert property (cap_evt && capcfg_r[CAP_CLR] && !wr_cnt[IDX_C]
                                |=> cnt_r[IDX_C] == '0)
    else $error("aux c not cleared after capture");

  // Core two reload from capture register on overflow
  AST_RELOAD_TWO: assert property (ovf[IDX_TWO] && ctl_r[IDX_TWO][CTL_RELTWO]
                                   && !wr_cnt[IDX_TWO]
                                   |=> cnt_r[IDX_TWO] == $past(capture_reload_register_r))
    else $error("core two reload wrong");

  // Low pin in gate-high mode blocks counting of aux a
  AST_GATE: assert property (mode[IDX_A] == MODE_GATE_HI && !sync_r[IDX_A] && !wr_cnt[IDX_A]
                             |=> $stable(cnt_r[IDX_A]))
    else $error("aux a counted with gate closed");

  // Overflow reaches status and then the interrupt line when unmasked
  AST_IRQ: assert property (ovf[IDX_ONE] && mask_r[IDX_ONE] && !wr_ctl[IDX_ONE]
                            && !(reg_write && reg_addr == ADR_MASK)
                            |=> stat_r[IDX_ONE] ##1 irq)
    else $error("overflow interrupt missing");

  // Main scenarios
  COV_PWM: cover property (rel_aux[IDX_A] ##[1:1000] rel_aux[IDX_B]);
  COV_CAPTURE_CLEAR: cover property (cap_evt && capcfg_r[CAP_CLR]);
  COV_DIR_PIN: cover property (ctl_r[IDX_ONE][CTL_EXTDIR] && ovf[IDX_ONE] && down[IDX_ONE]);
  COV_IRQ: cover property (irq);

endmodule

// ---- logic/gpt_pkg.sv ----
// ****************************************************************
// Constants shared by the timer unit
// ****************************************************************
package gpt_pkg;

  // Register port geometry
  localparam int BUS_W  = 16;
  localparam int ADDR_W = 8;

  // Timer indices: module one holds a, one, b; module two holds c, two
  localparam int N_TMR   = 5;
  localparam int IDX_A   = 0;
  localparam int IDX_ONE = 1;
  localparam int IDX_B   = 2;
  localparam int IDX_C   = 3;
  localparam int IDX_TWO = 4;

  // Synchronised pin indices (0..2 are the per-timer input pins)
  localparam int N_PIN   = 5;
  localparam int PIN_DIR = 3;
  localparam int PIN_CAP = 4;

  // Count resolution of each module at the reference CPU clock
  localparam int RES1_NS   = 400;
  localparam int RES2_NS   = 200;
  localparam int CPU_MHZ   = 20;
  localparam int BASE1_CYC = (RES1_NS * CPU_MHZ + 999) / 1000;
  localparam int BASE2_CYC = (RES2_NS * CPU_MHZ + 999) / 1000;
  localparam int PRE_W     = 8;

  // Register addresses
  localparam logic [7:0] ADR_CTL_BASE = 8'h00;
  localparam logic [7:0] ADR_CNT_BASE = 8'h08;
  localparam logic [7:0] ADR_CAPTURE_RELOAD_REGISTER   = 8'h10;
  localparam logic [7:0] ADR_CAPCFG   = 8'h11;
  localparam logic [7:0] ADR_STAT     = 8'h12;
  localparam logic [7:0] ADR_MASK     = 8'h13;

  // Timer control fields
  localparam int CTL_PS_LSB   = 0;
  localparam int PS_W         = 3;
  localparam int CTL_MODE_LSB = 3;
  localparam int MODE_W       = 3;
  localparam int CTL_RUN      = 6;
  localparam int CTL_DOWN     = 7;
  localparam int CTL_EXTDIR   = 8;
  localparam int CTL_TOGOUT   = 9;
  localparam int CTL_EDGE_LSB = 10;
  localparam int CTL_TLTRIG   = 12;
  localparam int CTL_RELTWO   = 13;

  // Capture configuration fields
  localparam int CAP_EDGE_LSB = 0;
  localparam int CAP_CLR      = 2;

  // Interrupt status layout: bits 0..4 timers, bit 5 capture
  localparam int N_IRQ  = 6;
  localparam int ST_CAP = 5;

  // Reset values
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] REG_RST = 16'h0000;

  typedef enum logic [2:0] {
    MODE_TIMER     = 3'h0,
    MODE_COUNTER   = 3'h1,
    MODE_GATE_LO   = 3'h2,
    MODE_GATE_HI   = 3'h3,
    MODE_RELOAD    = 3'h4,
    MODE_CAPTURE   = 3'h5,
    MODE_LATCH_CLK = 3'h6
  } mode_t;

endpackage

// ---- bench/gpt_pin_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// External pin driver standing beside the timer unit
// ****************************************************************
module gpt_pin_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Requests from the bench
  input  wire logic [2:0] in_req,
  input  wire logic       dir_req,
  input  wire logic       cap_req,
  // Pins toward the unit
  output logic      [2:0] aux_timer_input_pin,
  output logic            core_one_direction_pin,
  output logic            capture_trigger_pin
);
  // Pins change only just after a clock edge, as a board driver would
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_timer_input_pin    <= 3'h0;
      core_one_direction_pin <= 1'b0;
      capture_trigger_pin    <= 1'b0;
    end else begin
      aux_timer_input_pin    <= in_req;
      core_one_direction_pin <= dir_req;
      capture_trigger_pin    <= cap_req;
    end
  end
endmodule

// ---- bench/general_purpose_timer_unit_test.sv ----
`timescale 1ns/10ps
module general_purpose_timer_unit_test;
  import gpt_pkg::*;
  logic        clk;
  logic        reset_n;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [15:0] reg_rdata;
  logic [2:0]  in_req;
  logic        dir_req;
  logic        cap_req;
  logic [2:0]  aux_pin;
  logic        dir_pin;
  logic        cap_pin;
  logic        tog1;
  logic        tog2;
  logic        tb_clk;
  logic        irq;
  logic        tog_q;
  logic [15:0] v;
  int          n_mismatch;
  int          num_checks;
  int          cycles;
  int          n_tog;
  int          n_tb;
  int          t0;

  // ****************************************************************
  // Design, pin model and clock
  // ****************************************************************
  gpt_unit DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .aux_timer_input_pin(aux_pin), .core_one_direction_pin(dir_pin),
    .capture_trigger_pin(cap_pin), .core_one_toggle_pin(tog1), .core_two_toggle_pin(tog2),
    .cc_time_base_clock(tb_clk), .irq(irq));
  gpt_pin_model pins (.clk(clk), .reset_n(reset_n), .in_req(in_req), .dir_req(dir_req),
    .cap_req(cap_req), .aux_timer_input_pin(aux_pin), .core_one_direction_pin(dir_pin),
    .capture_trigger_pin(cap_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Toggle edges, time-base pulses and the hang limit
  always @(posedge clk) begin
    tog_q <= tog1;
    if (tog_q !== tog1) n_tog++;
    if (tb_clk === 1'b1) n_tb++;
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask

  // Read a counter and accept a window of values
  task automatic rdrng(input logic [7:0] a, input logic [15:0] lo, input logic [15:0] hi);
    rd(a, v);
    chk({15'h0000, (v >= lo) && (v <= hi)}, 16'h0001);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One pin pulse, 10 cycles high then 10 low; 3 means the capture pin
  task automatic pulse(input int p);
    if (p == 3) cap_req <= 1'b1;
    else in_req[p] <= 1'b1;
    cyc(10);
    if (p == 3) cap_req <= 1'b0;
    else in_req[p] <= 1'b0;
    cyc(10);
  endtask

  function automatic logic [7:0] ctl(input int i);
    return ADR_CTL_BASE + 8'(i);
  endfunction

  function automatic logic [7:0] cnt(input int i);
    return ADR_CNT_BASE + 8'(i);
  endfunction

  // Free run for 80 cycles and check the step count
  task automatic rate(input int i, input logic [15:0] c, input logic [15:0] lo,
                      input logic [15:0] hi);
    wr(cnt(i), 16'h0000);
    wr(ctl(i), c);
    cyc(80);
    wr(ctl(i), 16'h0000);
    rdrng(cnt(i), lo, hi);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    in_req = 3'h0;
    dir_req = 1'b0;
    cap_req = 1'b0;
    cyc(12);
    reset_n <= 1'b1;
    rdchk(cnt(IDX_ONE), REG_RST);
    rdchk(8'h30, 16'h0000);
    $display("test reset done");
    // Underflow, interrupt mask and clear, toggle latch
    wr(ADR_STAT, 16'h003F);
    wr(ADR_MASK, 16'h0002);
    wr(cnt(IDX_ONE), 16'h0000);
    wr(ctl(IDX_A), 16'h0470);
    wr(ctl(IDX_ONE), 16'h02C0);
    cyc(20);
    wr(ctl(IDX_ONE), 16'h0280);
    rdchk(ADR_STAT, 16'h0002);
    chk({15'h0000, irq}, 16'h0001);
    chk({15'h0000, tog1}, 16'h0001);
    rdrng(cnt(IDX_ONE), 16'hFFFC, 16'hFFFF);
    rdchk(cnt(IDX_A), 16'h0001);
    wr(ADR_MASK, 16'h0000);
    cyc(2);
    chk({15'h0000, irq}, 16'h0000);
    wr(ADR_MASK, 16'h0002);
    wr(ADR_STAT, 16'h0002);
    cyc(2);
    chk({15'h0000, irq}, 16'h0000);
    rdchk(ADR_STAT, 16'h0000);
    $display("test interrupt done");
    rate(IDX_ONE, 16'h0040, 16'h0009, 16'h000B);
    rate(IDX_ONE, 16'h0041, 16'h0004, 16'h0006);
    rate(IDX_TWO, 16'h0040, 16'h0013, 16'h0015);
    rate(IDX_TWO, 16'h0041, 16'h0009, 16'h000B);
    $display("test rates done");
    // Direction pin reverses core one
    wr(cnt(IDX_ONE), 16'h0005);
    dir_req <= 1'b1;
    cyc(5);
    wr(ctl(IDX_ONE), 16'h0140);
    cyc(80);
    wr(ctl(IDX_ONE), 16'h0000);
    dir_req <= 1'b0;
    rdrng(cnt(IDX_ONE), 16'hFFFA, 16'hFFFC);
    // Gated on high level of its pin
    wr(cnt(IDX_A), 16'h0000);
    wr(ctl(IDX_A), 16'h0058);
    cyc(80);
    rdchk(cnt(IDX_A), 16'h0000);
    in_req[0] <= 1'b1;
    cyc(80);
    in_req[0] <= 1'b0;
    cyc(10);
    wr(ctl(IDX_A), 16'h0000);
    rdrng(cnt(IDX_A), 16'h0008, 16'h000C);
    // Gated on low level of its pin
    in_req[0] <= 1'b1;
    wr(cnt(IDX_A), 16'h0000);
    wr(ctl(IDX_A), 16'h0050);
    cyc(40);
    rdchk(cnt(IDX_A), 16'h0000);
    in_req[0] <= 1'b0;
    cyc(40);
    wr(ctl(IDX_A), 16'h0000);
    rdrng(cnt(IDX_A), 16'h0003, 16'h0006);
    // Counter on rising pin edges
    wr(cnt(IDX_B), 16'h0000);
    wr(ctl(IDX_B), 16'h0448);
    repeat (3) pulse(2);
    rdchk(cnt(IDX_B), 16'h0003);
    $display("test modes done");
    // Capture core one into aux a, then reload from aux b
    wr(ctl(IDX_B), 16'h0000);
    wr(cnt(IDX_ONE), 16'h1234);
    wr(cnt(IDX_A), 16'h0000);
    wr(ctl(IDX_A), 16'h0428);
    pulse(0);
    rdchk(cnt(IDX_A), 16'h1234);
    cyc(40);
    rdchk(cnt(IDX_A), 16'h1234);
    wr(cnt(IDX_B), 16'h0055);
    wr(ctl(IDX_B), 16'h0420);
    pulse(2);
    rdchk(cnt(IDX_ONE), 16'h0055);
    // Alternate reloads on opposite latch edges keep the pin toggling
    wr(cnt(IDX_A), 16'h0003);
    wr(cnt(IDX_B), 16'h0005);
    wr(ctl(IDX_A), 16'h1420);
    wr(ctl(IDX_B), 16'h1820);
    wr(cnt(IDX_ONE), 16'h0000);
    wr(ctl(IDX_ONE), 16'h02C0);
    t0 = n_tog;
    cyc(400);
    chk({15'h0000, (n_tog - t0) >= 4}, 16'h0001);
    wr(ctl(IDX_ONE), 16'h0000);
    $display("test coupling done");
    // Capture aux c into the capture register with clear
    wr(ADR_STAT, 16'h003F);
    wr(ADR_MASK, 16'h0020);
    wr(cnt(IDX_C), 16'h0042);
    wr(ADR_CAPCFG, 16'h0005);
    pulse(3);
    rdchk(ADR_CAPTURE_RELOAD_REGISTER, 16'h0042);
    rdchk(cnt(IDX_C), 16'h0000);
    rdchk(ADR_STAT, 16'h0020);
    chk({15'h0000, irq}, 16'h0001);
    // Core two underflow: reload, time-base pulse, toggle pin
    t0 = n_tb;
    wr(ctl(IDX_C), 16'h0470);
    wr(cnt(IDX_TWO), 16'h0000);
    wr(ctl(IDX_TWO), 16'h22C0);
    cyc(10);
    wr(ctl(IDX_TWO), 16'h0200);
    rdrng(cnt(IDX_TWO), 16'h003E, 16'h0042);
    chk(16'(n_tb - t0), 16'h0001);
    chk({15'h0000, tog2}, 16'h0001);
    rdchk(cnt(IDX_C), 16'h0001);
    $display("test module two done");
    summarize();
  end
endmodule
